// ===== pdo_cc_model.sv
// controller model: bus choice, one-hot address, then execute
`timescale 1ns/1ps
`default_nettype none
module pdo_cc_model
  import pdo_pkg::*;
#(
  parameter int SCYC = 12
) (
  input  wire logic             mclk,
  output logic                  bus0_choice,
  output logic                  bus1_choice,
  output logic      [ADR_W-1:0] bus0_addr,
  output logic      [ADR_W-1:0] bus1_addr,
  output logic                  exec_in
);
  // idle levels at time zero
  initial begin
    {bus1_choice, bus0_choice} = 2'h0;
    bus0_addr = '0;
    bus1_addr = '0;
    exec_in = 1'b0;
  end

  // short choice pulse, address on the chosen bus only, inverse on the other
  task automatic order(input logic b, input logic [ADR_W-1:0] a);
    {bus1_choice, bus0_choice} <= b ? 2'h2 : 2'h1;
    bus0_addr <= b ? ~a : a;
    bus1_addr <= b ? a : ~a;
    repeat (3) @(posedge mclk);
    {bus1_choice, bus0_choice} <= 2'h0;
    repeat (SCYC + 3) @(posedge mclk);
    bus0_addr <= ~bus0_addr;                        // released: stale data flips
    bus1_addr <= ~bus1_addr;
  endtask

  // execute on this distributor's private lead, after a delay
  task automatic exe(input int dly);
    repeat (dly) @(posedge mclk);
    exec_in <= 1'b1;
    repeat (3) @(posedge mclk);
    exec_in <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== pdo_pkg.sv
// constants, register map and field positions for the order port
`default_nettype none
package pdo_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int STRETCH_NS    = 1800; // stretched bus choice
  localparam int EXEC_NS       = 500;  // reshaped execute pulse
  localparam int HOLD_NS       = 2000; // address hold after registering
  localparam int STRETCH_CYC   = (STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXEC_CYC      = (EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC      = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // code widths
  localparam int X_W   = 8;
  localparam int Y_W   = 8;
  localparam int Z_W   = 16;
  localparam int ADR_W = X_W + Y_W + Z_W;
  localparam int VER_W = 24;
  localparam int CNT_W = 16;
  localparam int ROW_W = 6;
  localparam int COL_W = 4;

  // control lead bit positions in the synchronised vector
  localparam int CL_CH0  = 0;
  localparam int CL_CH1  = 1;
  localparam int CL_EXE  = 2;
  localparam int CL_TEST = 3;
  localparam int CL_RST  = 4;
  localparam int CL_W    = 5;

  // highest z position that still selects a unipolar output
  localparam logic [COL_W-1:0] Z_UNI_LAST = 4'h7;

  // register offsets (byte addresses)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ADDR   = 4'h8;
  localparam logic [3:0] REG_COUNT  = 4'hC;

  // control register fields and reset values
  localparam int CTRL_COMMIT = 0;
  localparam int CTRL_MAINT  = 1;
  localparam logic [1:0] CTRL_RST_VAL = 2'h1;

  // status register fields
  localparam int ST_BUS    = 0;
  localparam int ST_TEST   = 1;
  localparam int ST_VALID  = 2;
  localparam int ST_PX     = 3;
  localparam int ST_PY     = 4;
  localparam int ST_PZ     = 5;
  localparam int ST_HEALTH = 6;

endpackage
`default_nettype wire

// ===== pdo_pulse_tmr.sv
// retriggerable pulse timer: active for CYC cycles, then a done pulse
`timescale 1ns/1ps
`default_nettype none
module pdo_pulse_tmr #(
  parameter int CYC = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  pdo_tmr_if.timer t
);
  localparam int W    = $clog2(CYC + 1);
  localparam int TLEN = CYC - 2; // cycles from end of antecedent to last active
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         active;
    logic         done;
  } pdo_tmr_st_t;
  pdo_tmr_st_t q;
  pdo_tmr_st_t d;

  // count down from a trigger, restart on a new one
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (t.trig) begin
      d.active = 1'b1;
      d.cnt    = W'(CYC - 1);
    end else if (q.active) begin
      if (q.cnt == '0) begin
        d.active = 1'b0;
        d.done   = 1'b1;
      end else begin
        d.cnt = q.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign t.active = q.active;
  assign t.done   = q.done;

  // a lone trigger gives exactly CYC active cycles then done
  a_tmr_length: assert property (@(posedge mclk) disable iff (!rst_n)
    (t.trig && !q.active) ##1 (!t.trig)[*2] |-> ##TLEN (t.active && !t.done)
      ##1 (t.trig || (!t.active && t.done)))
    else $error("pulse timer length wrong");
  a_tmr_done_one: assert property (@(posedge mclk) disable iff (!rst_n)
    t.done |=> !t.done)
    else $error("timer done longer than one cycle");
endmodule
`default_nettype wire

// ===== pdo_tmr_if.sv
// trigger and status bundle between the order port and a pulse timer
`timescale 1ns/1ps
`default_nettype none
interface pdo_tmr_if;
  logic trig;
  logic active;
  logic done;
  modport timer (input trig, output active, output done);
  modport user  (output trig, input active, input done);
endinterface
`default_nettype wire

// ===== pdo_top.sv
// order reception, parity gating and answer-back of one pulse distributor
//
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pdo_top
  import pdo_pkg::*;
#(
  parameter int STR_CYC  = STRETCH_CYC,
  parameter int HLD_CYC  = HOLD_CYC,
  parameter int EXE_CYC  = EXEC_CYC
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              bus0_choice,
  input  wire logic              bus1_choice,
  input  wire logic [ADR_W-1:0]  bus0_addr,
  input  wire logic [ADR_W-1:0]  bus1_addr,
  input  wire logic              exec_in,
  input  wire logic              test_lead,
  input  wire logic              reset_lead,
  input  wire logic [VER_W-1:0]  verify_in,
  output logic                   ans_bus0_en,
  output logic                   ans_bus1_en,
  output logic                   echo_out,
  output logic                   commit_strobe,
  output logic      [2:0]        parity_ans,
  output logic      [VER_W-1:0]  verify_ans,
  output logic      [2:0]        maint_parity,
  output logic                   maint_ind,
  output logic                   health_ok_signal,
  output logic      [X_W-1:0]    predec_out,
  output logic      [X_W*Y_W-1:0] dec_out,
  output logic                   uni_fire,
  output logic                   bip_pos,
  output logic                   bip_neg,
  output logic      [ROW_W-1:0]  mat_row,
  output logic      [COL_W-1:0]  mat_col
);

  typedef struct packed {
    logic [2*ADR_W-1:0] a1;
    logic [2*ADR_W-1:0] a2;
    logic [CL_W-1:0]    c1;
    logic [CL_W-1:0]    c2;
    logic [CL_W-1:0]    cp;
    logic [VER_W-1:0]   v1;
    logic [VER_W-1:0]   v2;
    logic               bus_sel;
    logic               test;
    logic [X_W-1:0]     x;
    logic [Y_W-1:0]     y;
    logic [Z_W-1:0]     z;
    logic               px;
    logic               py;
    logic               pz;
    logic               valid;
    logic               health;
    logic               go;
    logic [X_W-1:0]     pre;
    logic [X_W*Y_W-1:0] dec;
    logic               uni;
    logic               bpos;
    logic               bneg;
    logic [ROW_W-1:0]   row;
    logic [COL_W-1:0]   col;
    logic               ans0;
    logic               ans1;
    logic               echo;
    logic               commit;
    logic [2:0]         pans;
    logic [VER_W-1:0]   vans;
    logic [1:0]         ctrl;
    logic [CNT_W-1:0]   fired;
    logic [CNT_W-1:0]   rejected;
    logic               wr;
    logic [31:0]        rdata;
    logic               mind;
    logic               hok;
  } pdo_state_t;

  pdo_state_t q;
  pdo_state_t d;

  // exactly one bit set: the legitimacy check on a one-hot code
  function automatic logic one_hot(input logic [Z_W-1:0] v);
    logic [4:0] n;
    n = '0;
    for (int i = 0; i < Z_W; i++) begin
      n = n + {4'h0, v[i]};
    end
    return (n == 5'h01);
  endfunction

  // index of the set bit of a one-hot word
  function automatic logic [ROW_W-1:0] enc(input logic [X_W*Y_W-1:0] v);
    logic [ROW_W-1:0] r;
    r = '0;
    for (int i = 0; i < X_W * Y_W; i++) begin
      if (v[i]) begin
        r = ROW_W'(i);
      end
    end
    return r;
  endfunction

  pdo_tmr_if t_str ();
  pdo_tmr_if t_hold ();
  pdo_tmr_if t_exe ();

  pdo_pulse_tmr #(.CYC(STR_CYC)) u_stretch (.mclk(mclk), .rst_n(rst_n), .t(t_str));
  pdo_pulse_tmr #(.CYC(HLD_CYC)) u_hold    (.mclk(mclk), .rst_n(rst_n), .t(t_hold));
  pdo_pulse_tmr #(.CYC(EXE_CYC)) u_exec    (.mclk(mclk), .rst_n(rst_n), .t(t_exe));

  logic [CL_W-1:0]  rise;
  logic             choice;
  logic             par_ok;
  logic [ADR_W-1:0] sel_addr;
  logic [COL_W-1:0] zi;

  // edges of the synchronised leads and the selected bus
  assign rise     = q.c2 & ~q.cp;
  assign choice   = rise[CL_CH0] | rise[CL_CH1];
  assign par_ok   = q.px & q.py & q.pz;
  assign sel_addr = q.bus_sel ? q.a2[2*ADR_W-1:ADR_W] : q.a2[ADR_W-1:0];
  assign zi       = COL_W'(enc({48'h0, q.z}));

  // timer triggers: choice stretch, address hold, execute reshape
  assign t_str.trig  = choice;
  assign t_hold.trig = t_str.done;
  assign t_exe.trig  = rise[CL_EXE];

  always_comb begin
    d = q;
    // two-flop synchronisers for every pin except the register bus
    d.a1 = {bus1_addr, bus0_addr};
    d.a2 = q.a1;
    d.c1 = {reset_lead, test_lead, exec_in, bus1_choice, bus0_choice};
    d.c2 = q.c1;
    d.cp = q.c2;
    d.v1 = verify_in;
    d.v2 = q.v1;

    // test lead enters test mode, reset lead returns to normal
    if (rise[CL_TEST]) begin
      d.test = 1'b1;
    end else if (rise[CL_RST]) begin
      d.test = 1'b0;
    end

    // bus choice opens a new order and picks the answer bus
    if (choice) begin
      d.bus_sel = rise[CL_CH1];
      d.x       = '0;
      d.y       = '0;
      d.z       = '0;
      d.valid   = 1'b0;
    end else if (t_str.active) begin
      d.x = q.x | sel_addr[X_W-1:0];
      d.y = q.y | sel_addr[X_W+Y_W-1:X_W];
      d.z = q.z | sel_addr[ADR_W-1:X_W+Y_W];
    end

    // strobe at end of the gating window sets the parity flags
    if (t_str.done) begin
      d.px     = one_hot({8'h00, q.x});
      d.py     = one_hot({8'h00, q.y});
      d.pz     = one_hot(q.z);
      d.valid  = 1'b1;
      d.health = one_hot({8'h00, q.x}) & one_hot({8'h00, q.y}) & one_hot(q.z);
    end else if (t_hold.done) begin
      d.valid = 1'b0;
    end

    // execute: pass into the stages only with a good address
    if (rise[CL_EXE]) begin
      d.go = q.valid & par_ok & ~q.test;
      if (q.valid & par_ok & ~q.test) begin
        d.fired = q.fired + CNT_W'(1);
      end else begin
        d.rejected = q.rejected + CNT_W'(1);
      end
    end else if (t_exe.done) begin
      d.go = 1'b0;
    end

    // three selection stages: predecoder, decoder, matrix
    d.pre = q.go ? q.x : '0;
    for (int i = 0; i < X_W; i++) begin
      for (int j = 0; j < Y_W; j++) begin
        d.dec[i*Y_W+j] = q.pre[i] & q.y[j];
      end
    end
    d.row  = enc(q.dec);
    d.col  = zi;
    d.uni  = (|q.dec) & (zi <= Z_UNI_LAST);
    d.bpos = (|q.dec) & (zi > Z_UNI_LAST) & zi[0];
    d.bneg = (|q.dec) & (zi > Z_UNI_LAST) & ~zi[0];

    // answer-back while the execute pulse lasts
    d.ans0   = t_exe.active & ~q.bus_sel;
    d.ans1   = t_exe.active & q.bus_sel;
    d.echo   = t_exe.active;
    d.commit = t_exe.active & q.go & q.ctrl[CTRL_COMMIT];
    d.pans   = t_exe.active ? {q.pz, q.py, q.px} : 3'h0;
    d.vans   = t_exe.active ? q.v2 : '0;

    // register bus: one wait cycle, then answer
    d.wr = ~((avs_read | avs_write) & q.wr);
    if ((avs_read | avs_write) & q.wr) begin
      case (avs_address)
        REG_CTRL:   d.rdata = {30'h0, q.ctrl};
        REG_STATUS: d.rdata = {25'h0, q.health & ~q.test, q.pz, q.py, q.px,
                               q.valid, q.test, q.bus_sel};
        REG_ADDR:   d.rdata = {q.z, q.y, q.x};
        REG_COUNT:  d.rdata = {q.rejected, q.fired};
        default:    d.rdata = 32'h0;
      endcase
    end
    if (avs_write & ~q.wr & (avs_address == REG_CTRL)) begin
      d.ctrl = avs_writedata[1:0];
    end

    // maintenance leads registered from their next values
    d.mind = d.ctrl[CTRL_MAINT] | d.test;
    d.hok  = d.health & ~d.test;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q        <= '0;
      q.ctrl   <= CTRL_RST_VAL;
      q.health <= 1'b1;
      q.hok    <= 1'b1;
      q.wr     <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign avs_readdata     = q.rdata;
  assign avs_waitrequest  = q.wr;
  assign ans_bus0_en      = q.ans0;
  assign ans_bus1_en      = q.ans1;
  assign echo_out         = q.echo;
  assign commit_strobe    = q.commit;
  assign parity_ans       = q.pans;
  assign verify_ans       = q.vans;
  assign maint_parity     = {q.pz, q.py, q.px};
  assign maint_ind        = q.mind;
  assign health_ok_signal = q.hok;
  assign predec_out       = q.pre;
  assign dec_out          = q.dec;
  assign uni_fire         = q.uni;
  assign bip_pos          = q.bpos;
  assign bip_neg          = q.bneg;
  assign mat_row          = q.row;
  assign mat_col          = q.col;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_good_exec;
    rise[CL_EXE] && q.valid && par_ok && !q.test;
  endsequence
  sequence s_bad_exec;
    rise[CL_EXE] && !(q.valid && par_ok);
  endsequence
  sequence s_three_stages;
    ##2 (predec_out != '0) ##1 (dec_out != '0) ##1 (uni_fire || bip_pos || bip_neg);
  endsequence

  // checks next to the order logic
  a_bus_select: assert property (rise[CL_CH1] |=> q.bus_sel ##1 (t_str.active))
    else $error("bus one choice did not select bus one");
  a_stretch_gate: assert property (choice |=> t_str.active[*8])
    else $error("choice pulse not stretched");
  a_stage_reach: assert property (s_good_exec |-> s_three_stages)
    else $error("good execute did not reach the matrix");
  a_parity_gate: assert property (s_bad_exec |=> !q.go ##1 (predec_out == '0))
    else $error("execute passed with bad address");
  a_echo_return: assert property (rise[CL_EXE] |-> ##2 echo_out)
    else $error("no echo after execute");
  a_answer_bus: assert property (ans_bus0_en |-> !ans_bus1_en && !$past(q.bus_sel))
    else $error("answer on wrong bus");
  a_commit_variant: assert property (commit_strobe |-> $past(q.ctrl[CTRL_COMMIT]))
    else $error("commit strobe in later variant");
  a_hold_discard: assert property (t_hold.done && !choice && !t_str.done |=> !q.valid)
    else $error("address kept after hold");
  a_bipolar_sign: assert property (bip_pos |-> mat_col[0] && mat_col[3])
    else $error("positive bipolar on even position");
  a_parity_report: assert property (echo_out |-> parity_ans == maint_parity)
    else $error("parity answer differs from flags");
endmodule
`default_nettype wire

// ===== pdo_top_test.sv
// self-checking bench for the pulse distributor order port
`timescale 1ns/1ps
`default_nettype none
module pdo_top_test
  import pdo_pkg::*;
;
  localparam int SC = 12;
  localparam int HC = 20;
  localparam int EC = 6;
  logic             mclk = 1'b0;
  logic             rst_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0]       avs_address;
  logic [31:0]      avs_writedata, avs_readdata, d, r, last_adr;
  logic             b0c, b1c, exec_in, test_lead, reset_lead;
  logic [ADR_W-1:0] b0a, b1a;
  logic [VER_W-1:0] verify_in, verify_ans;
  logic             ab0, ab1, echo_out, commit_strobe, maint_ind, health_ok_signal;
  logic [2:0]       parity_ans, maint_parity;
  logic [7:0]       predec_out;
  logic [63:0]      dec_out;
  logic             uni_fire, bip_pos, bip_neg, ctrl0;
  logic [5:0]       mat_row;
  logic [3:0]       mat_col;
  int               mismatches, compares, nf, nr, i;
  int               seed = 32'h1A37E178;

  // clock
  always #10 mclk = ~mclk;

  pdo_cc_model #(.SCYC(SC)) m (.mclk(mclk), .bus0_choice(b0c), .bus1_choice(b1c),
    .bus0_addr(b0a), .bus1_addr(b1a), .exec_in(exec_in));

  pdo_top #(.STR_CYC(SC), .HLD_CYC(HC), .EXE_CYC(EC)) uut (.mclk(mclk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus0_choice(b0c), .bus1_choice(b1c),
    .bus0_addr(b0a), .bus1_addr(b1a), .exec_in(exec_in), .test_lead(test_lead),
    .reset_lead(reset_lead), .verify_in(verify_in), .ans_bus0_en(ab0), .ans_bus1_en(ab1),
    .echo_out(echo_out), .commit_strobe(commit_strobe), .parity_ans(parity_ans),
    .verify_ans(verify_ans), .maint_parity(maint_parity), .maint_ind(maint_ind),
    .health_ok_signal(health_ok_signal), .predec_out(predec_out), .dec_out(dec_out),
    .uni_fire(uni_fire), .bip_pos(bip_pos), .bip_neg(bip_neg), .mat_row(mat_row),
    .mat_col(mat_col));

  // compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                    output logic [31:0] rd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= ~wr;
    avs_write <= wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  // expected output kind for a z position: {uni, pos, neg}
  function automatic logic [2:0] pol(input int zi);
    return zi <= 7 ? 3'h4 : (zi % 2 ? 3'h2 : 3'h1);
  endfunction

  // pulse the test or the reset lead
  task automatic lead(input logic t);
    {test_lead, reset_lead} <= t ? 2'h2 : 2'h1;
    repeat (3) @(posedge mclk);
    {test_lead, reset_lead} <= 2'h0;
    repeat (4) @(posedge mclk);
  endtask

  // one full order; bad picks a broken code (1 x, 2 y, 3 z)
  task automatic run(input logic b, input int xi, yi, zi, bad, input logic late, tm);
    logic [7:0]  x, y;
    logic [15:0] z;
    logic [2:0]  par;
    logic [31:0] v;
    logic        go;
    int          k;
    x = 8'h1 << xi;
    y = bad == 2 ? 8'h0 : 8'h1 << yi;
    z = 16'h1 << zi;
    if (bad == 1) x ^= 8'h1 << ((xi + 1) % 8);
    if (bad == 3) z ^= 16'h1 << ((zi + 1) % 16);
    par = {bad != 3, bad != 2, bad != 1};
    go = &par & ~late & ~tm;
    v = $random(seed);
    verify_in <= v[VER_W-1:0];
    last_adr = {z, y, x};
    m.order(b, last_adr);
    repeat (2) @(posedge mclk);
    chk(maint_parity, par);
    chk(health_ok_signal, &par & ~tm);
    m.exe(late ? HC + 10 : 0);
    for (k = 0; echo_out !== 1'b1 && k < 20; k++) @(posedge mclk);
    chk({ab1, ab0}, b ? 2'h2 : 2'h1);
    chk(parity_ans, par);
    chk(verify_ans, v[VER_W-1:0]);
    chk(commit_strobe, go & ctrl0);
    chk(predec_out, go ? x : 8'h0);
    for (k = 0; echo_out === 1'b1 && k < 40; k++) begin
      if (k == 2) begin
        chk(dec_out, go ? 64'h1 << (xi * 8 + yi) : 64'h0);
        chk({uni_fire, bip_pos, bip_neg}, go ? pol(zi) : 3'h0);
        if (go) chk({mat_row, mat_col}, {6'(xi * 8 + yi), 4'(zi)});
      end
      @(posedge mclk);
    end
    chk(k, EC);
    if (go) nf++;
    else nr++;
    repeat (4) @(posedge mclk);
  endtask

  // verdict and end of run
  task automatic print_verdict;
    $display("counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    print_verdict;
  end

  // main sequence
  initial begin
    {rst_n, avs_read, avs_write, test_lead, reset_lead} = 5'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    verify_in = '0;
    ctrl0 = 1'b1;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    av(1'b0, REG_CTRL, 32'h0, d);
    chk(d, 32'h1);
    av(1'b1, 4'h2, $random(seed), d);
    av(1'b0, 4'h2, 32'h0, d);
    chk(d, 32'h0);
    m.exe(0);
    repeat (12) @(posedge mclk);
    chk(predec_out, 8'h0);
    nr++;
    $display("test reset and registers done");
    for (i = 0; i < 16; i++) run(i[0], i % 8, 7 - i % 8, i, 0, 1'b0, 1'b0);
    for (i = 1; i < 4; i++) run(i[1], i, i + 2, 8 + i, i, 1'b0, 1'b0);
    run(1'b1, 3, 4, 9, 0, 1'b1, 1'b0);
    $display("test codes, parity and hold done");
    av(1'b1, REG_CTRL, 32'h2, d);
    ctrl0 = 1'b0;
    chk(maint_ind, 1'b1);
    run(1'b0, 5, 2, 3, 0, 1'b0, 1'b0);
    av(1'b1, REG_CTRL, 32'h1, d);
    ctrl0 = 1'b1;
    lead(1'b1);
    chk(maint_ind, 1'b1);
    run(1'b1, 1, 6, 12, 0, 1'b0, 1'b1);
    lead(1'b0);
    chk(maint_ind, 1'b0);
    $display("test commit and test mode done");
    for (i = 0; i < 20; i++) begin
      r = $random(seed);
      run(r[0], r[16:14], r[19:17], {r[9], r[22:20]}, r[12:11], 1'b0, 1'b0);
    end
    av(1'b1, REG_ADDR, $random(seed), d);
    av(1'b0, REG_ADDR, 32'h0, d);
    chk(d, last_adr);
    av(1'b0, REG_COUNT, 32'h0, d);
    chk(d, {16'(nr), 16'(nf)});
    $display("test random orders done");
    print_verdict;
  end
endmodule
`default_nettype wire
